/* File: common/csfv_params.svh */
// constants for the status flag and vector unit
`ifndef CSFV_PARAMS_SVH
`define CSFV_PARAMS_SVH
// ==========================================
// reset vectors
`define CSFV_VEC_NRM_POR 16'hFFFE
`define CSFV_VEC_NRM_CLK 16'hFFFC
`define CSFV_VEC_NRM_WDG 16'hFFFA
`define CSFV_VEC_TST_POR 16'hBFFE
`define CSFV_VEC_TST_CLK 16'hBFFC
`define CSFV_VEC_TST_WDG 16'hBFFA
// reset cause codes
`define CSFV_CAUSE_POR 2'h0
`define CSFV_CAUSE_CLK 2'h1
`define CSFV_CAUSE_WDG 2'h2
// ==========================================
// flag register bit positions
`define CSFV_FB_C 0
`define CSFV_FB_V 1
`define CSFV_FB_Z 2
`define CSFV_FB_N 3
`define CSFV_FB_I 4
`define CSFV_FB_H 5
`define CSFV_FB_X 6
`define CSFV_FB_S 7
`define CSFV_FLAGS_RST 8'hD0
// ==========================================
// register byte offsets
`define CSFV_OFF_OP 8'h00
`define CSFV_OFF_OPND 8'h04
`define CSFV_OFF_RES 8'h08
`define CSFV_OFF_FLAGS 8'h0C
`define CSFV_OFF_PTR 8'h10
`define CSFV_OFF_SP 8'h14
`define CSFV_OFF_STAT 8'h18
`define CSFV_OFF_FETCH 8'h1C
// ==========================================
// operation codes
`define CSFV_OP_LOAD 5'h00
`define CSFV_OP_STORE 5'h01
`define CSFV_OP_ADD 5'h02
`define CSFV_OP_ADC 5'h03
`define CSFV_OP_ABA 5'h04
`define CSFV_OP_SUB 5'h05
`define CSFV_OP_CMP 5'h06
`define CSFV_OP_INC16 5'h07
`define CSFV_OP_DEC16 5'h08
`define CSFV_OP_ABX 5'h09
`define CSFV_OP_MOVE 5'h0A
`define CSFV_OP_ROL 5'h0B
`define CSFV_OP_MUL 5'h0C
`define CSFV_OP_TAP 5'h0D
`define CSFV_OP_CLI 5'h0E
`define CSFV_OP_STOP 5'h0F
`define CSFV_OP_ACCEPT 5'h10
`define CSFV_OP_XACCEPT 5'h11
`define CSFV_OP_RTI 5'h12
`endif

/* File: common/csfv_pkg.sv */
// types for the status flag and vector unit
package csfv_pkg;
  // ==========================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_CAPTURE, ST_VEC_HI, ST_VEC_LO, ST_IDLE, ST_PUSH, ST_MASK, ST_PULL
  } csfv_state_t;
  // ==========================================
  // whole state of the core, one packed struct
  typedef struct packed {
    csfv_state_t st;
    logic [1:0] step;
    logic [15:0] ptr;
    logic [15:0] sp;
    logic [15:0] vaddr;
    logic [15:0] res;
    logic [7:0] flags;
    logic mode;
    logic [1:0] cause;
    logic [1:0] page;
    logic [7:0] fopc;
    logic [2:0] flen;
    logic stopped;
    logic xacc;
    logic wb_ack;
    logic [31:0] wb_dat;
    logic mem_req;
    logic mem_we;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] opa;
    logic [7:0] opb;
    logic [15:0] opw;
  } csfv_regs_t;
endpackage

/* File: hw/csfv_flag_alu.sv */
// result and flag computation for one operation
`timescale 1ns/1ps
`include "csfv_params.svh"
module csfv_flag_alu import csfv_pkg::*; (
  input wire logic [4:0] op_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic [15:0] w_in,
  input wire logic [7:0] flags_in,
  output logic [15:0] res_out,
  output logic [7:0] flags_out
);
  // ==========================================
  // combinational datapath
  always_comb begin
    logic [8:0] s9;
    logic [4:0] h5;
    logic [15:0] w16;
    s9 = '0;
    h5 = '0;
    w16 = '0;
    res_out = {8'h00, a_in};
    flags_out = flags_in; // default: no flag touched
    case (op_in)
      `CSFV_OP_LOAD, `CSFV_OP_STORE: begin
        flags_out[`CSFV_FB_N] = a_in[7]; // RULE_10
        flags_out[`CSFV_FB_Z] = (a_in == 8'h00); // RULE_08
        flags_out[`CSFV_FB_V] = 1'b0; // RULE_05
      end
      `CSFV_OP_ADD, `CSFV_OP_ADC, `CSFV_OP_ABA: begin
        // carry in only for add-with-carry
        s9 = {1'b0, a_in} + {1'b0, b_in}
          + {8'h00, (op_in == `CSFV_OP_ADC) & flags_in[`CSFV_FB_C]};
        h5 = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]}
          + {4'h0, (op_in == `CSFV_OP_ADC) & flags_in[`CSFV_FB_C]};
        res_out = {8'h00, s9[7:0]};
        flags_out[`CSFV_FB_H] = h5[4]; // RULE_14
        flags_out[`CSFV_FB_C] = s9[8]; // RULE_06
        flags_out[`CSFV_FB_V] = (a_in[7] == b_in[7]) && (s9[7] != a_in[7]); // RULE_07
        flags_out[`CSFV_FB_N] = s9[7]; // RULE_10
        flags_out[`CSFV_FB_Z] = (s9[7:0] == 8'h00); // RULE_08
      end
      `CSFV_OP_SUB, `CSFV_OP_CMP: begin
        // compare shares the subtraction, caller drops the result
        s9 = {1'b0, a_in} - {1'b0, b_in};
        res_out = {8'h00, s9[7:0]};
        flags_out[`CSFV_FB_C] = s9[8]; // RULE_06
        flags_out[`CSFV_FB_V] = (a_in[7] != b_in[7]) && (s9[7] != a_in[7]); // RULE_07
        flags_out[`CSFV_FB_N] = s9[7]; // RULE_10
        flags_out[`CSFV_FB_Z] = (s9[7:0] == 8'h00); // RULE_08
      end
      `CSFV_OP_INC16, `CSFV_OP_DEC16: begin
        w16 = (op_in == `CSFV_OP_INC16) ? w_in + 16'h0001 : w_in - 16'h0001;
        res_out = w16;
        flags_out[`CSFV_FB_Z] = (w16 == 16'h0000); // RULE_09
      end
      `CSFV_OP_ABX: res_out = w_in + {8'h00, b_in}; // RULE_05
      `CSFV_OP_ROL: begin
        // carry rotates in as the ninth bit
        res_out = {8'h00, a_in[6:0], flags_in[`CSFV_FB_C]}; // RULE_06
        flags_out[`CSFV_FB_C] = a_in[7];
        flags_out[`CSFV_FB_N] = a_in[6];
        flags_out[`CSFV_FB_Z] = ({a_in[6:0], flags_in[`CSFV_FB_C]} == 8'h00);
        flags_out[`CSFV_FB_V] = a_in[6] ^ a_in[7];
      end
      `CSFV_OP_MUL: begin
        w16 = {8'h00, a_in} * {8'h00, b_in};
        res_out = w16;
        flags_out[`CSFV_FB_C] = w16[7]; // RULE_06
      end
      `CSFV_OP_TAP: begin
        // the pin mask may be cleared from a but never set
        flags_out = {a_in[7], flags_in[6] & a_in[6], a_in[5:0]}; // RULE_17
      end
      default: ; // moves and control ops leave flags alone
    endcase
  end
endmodule

/* File: hw/csfv_core.sv */
// status flag register, instruction pointer and vector sequencer
//
// Summary of operation
// RULE_01 - 16-bit pointer loads reset vector after reset
// RULE_02 - normal mode vectors FFFE, FFFC, FFFA
// RULE_03 - test mode vectors BFFE, BFFC, BFFA
// RULE_04 - flag register is eight bits wide
// RULE_05 - loads/stores set NZV; moves touch nothing
// RULE_06 - carry from add/borrow, multiply, rotate
// RULE_07 - overflow set on arithmetic overflow only
// RULE_08 - zero flag on zero result; compares discard
// RULE_09 - index increment/decrement change only zero
// RULE_10 - negative copies result top bit
// RULE_11 - maskable interrupts pend but wait on mask
// RULE_12 - reset sets mask; only instructions clear
// RULE_13 - accept sets mask after stacking, before vector
// RULE_14 - half carry from bit 3 on adds
// RULE_15 - pin mask blocks pin interrupt; reset sets
// RULE_16 - pin accept sets both masks after stacking
// RULE_17 - pin mask cleared only by transfer/return
// RULE_18 - stop disable makes stop a no-op
// RULE_19 - words high byte first, no alignment
// RULE_20 - prefix byte moves decode to pages 1-3
// RULE_21 - instruction is one to five bytes
// RULE_22 - interrupt return pulls context in reverse
// RULE_23 - vector read high byte, then low byte
`timescale 1ns/1ps
`include "csfv_params.svh"
module csfv_core import csfv_pkg::*; #(
  parameter logic [7:0] PREFIX1 = 8'h18, // page 1 prefix
  parameter logic [7:0] PREFIX2 = 8'h1A, // page 2 prefix
  parameter logic [7:0] PREFIX3 = 8'hCD, // page 3 prefix
  parameter logic [15:0] SP_RST = 16'h00FF // stack pointer after reset
) (
  input wire logic clk_in,
  input wire logic rst_in,
  // wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // mode and reset cause, caught after reset release
  input wire logic test_mode_in,
  input wire logic [1:0] reset_cause_in,
  // interrupt requests
  input wire logic irq_in,
  input wire logic dedicated_pin_interrupt_in,
  output logic irq_take_out,
  output logic pin_take_out,
  // byte memory port
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [15:0] mem_addr_out,
  output logic [7:0] mem_wdata_out,
  input wire logic [7:0] mem_rdata_in,
  input wire logic mem_ack_in,
  // core state
  output logic [15:0] next_instruction_pointer_out,
  output logic [7:0] flag_register_out,
  output logic stop_out
);
  // ==========================================
  // state and helpers
  csfv_regs_t r_r; // registered state
  csfv_regs_t r_nxt; // next state
  logic [15:0] alu_res; // alu result
  logic [7:0] alu_flags; // alu flags
  logic wb_new; // fresh bus request
  logic wr_op; // operation write taken
  logic [4:0] op_code; // operation from bus

  // reset value of the whole state
  localparam csfv_regs_t RST_VAL = '{
    st: ST_CAPTURE, step: 2'h0, ptr: 16'h0000, sp: SP_RST,
    vaddr: 16'h0000, res: 16'h0000, flags: `CSFV_FLAGS_RST,
    mode: 1'b0, cause: 2'h0, page: 2'h0, fopc: 8'h00, flen: 3'h0,
    stopped: 1'b0, xacc: 1'b0, wb_ack: 1'b0, wb_dat: 32'h0000_0000,
    mem_req: 1'b0, mem_we: 1'b0, mem_addr: 16'h0000,
    mem_wdata: 8'h00, opa: 8'h00, opb: 8'h00, opw: 16'h0000};

  // byte-lane merge for 16-bit registers
  function automatic logic [15:0] wr16(input logic [15:0] old,
                                       input logic [15:0] d,
                                       input logic [1:0] sel);
    wr16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  // vector table by mode and cause
  function automatic logic [15:0] vec_sel(input logic test,
                                          input logic [1:0] cause);
    case (cause)
      `CSFV_CAUSE_CLK: vec_sel = test ? `CSFV_VEC_TST_CLK : `CSFV_VEC_NRM_CLK;
      `CSFV_CAUSE_WDG: vec_sel = test ? `CSFV_VEC_TST_WDG : `CSFV_VEC_NRM_WDG;
      default: vec_sel = test ? `CSFV_VEC_TST_POR : `CSFV_VEC_NRM_POR;
    endcase
  endfunction

  // ==========================================
  // flag datapath
  csfv_flag_alu u_alu (
    .op_in(op_code),
    .a_in(r_r.opa),
    .b_in(r_r.opb),
    .w_in(r_r.opw),
    .flags_in(r_r.flags),
    .res_out(alu_res),
    .flags_out(alu_flags)
  );

  assign op_code = wb_dat_in[4:0];
  // ack high means the request was already answered
  assign wb_new = wb_cyc_in && wb_stb_in && !r_r.wb_ack;
  // operations are taken only while idle; others are dropped
  assign wr_op = wb_new && wb_we_in && wb_sel_in[0]
    && (wb_adr_in == `CSFV_OFF_OP) && (r_r.st == ST_IDLE);

  // ==========================================
  // next state
  always_comb begin
    r_nxt = r_r;
    r_nxt.wb_ack = wb_new;
    // bus read mux, unmapped reads answer zero
    if (wb_new && !wb_we_in) begin
      case (wb_adr_in)
        `CSFV_OFF_OPND: r_nxt.wb_dat = {r_r.opw, r_r.opb, r_r.opa};
        `CSFV_OFF_RES: r_nxt.wb_dat = {16'h0000, r_r.res};
        `CSFV_OFF_FLAGS: r_nxt.wb_dat = {24'h000000, r_r.flags}; // RULE_04
        `CSFV_OFF_PTR: r_nxt.wb_dat = {16'h0000, r_r.ptr};
        `CSFV_OFF_SP: r_nxt.wb_dat = {16'h0000, r_r.sp};
        `CSFV_OFF_STAT: r_nxt.wb_dat = {24'h000000, pin_take_out, irq_take_out,
          r_r.stopped, r_r.cause, r_r.mode, r_r.page != 2'h0, r_r.st != ST_IDLE};
        `CSFV_OFF_FETCH: r_nxt.wb_dat = {19'h00000, r_r.flen, r_r.page, r_r.fopc};
        default: r_nxt.wb_dat = 32'h0000_0000;
      endcase
    end
    // plain register writes, honoured only when idle
    if (wb_new && wb_we_in && r_r.st == ST_IDLE) begin
      case (wb_adr_in)
        `CSFV_OFF_OPND: begin
          if (wb_sel_in[0]) r_nxt.opa = wb_dat_in[7:0];
          if (wb_sel_in[1]) r_nxt.opb = wb_dat_in[15:8];
          r_nxt.opw = wr16(r_r.opw, wb_dat_in[31:16], wb_sel_in[3:2]);
        end
        `CSFV_OFF_PTR: r_nxt.ptr = wr16(r_r.ptr, wb_dat_in[15:0], wb_sel_in[1:0]);
        `CSFV_OFF_SP: r_nxt.sp = wr16(r_r.sp, wb_dat_in[15:0], wb_sel_in[1:0]);
        `CSFV_OFF_FETCH: begin
          // prefix byte only redirects the next opcode
          if (wb_sel_in[0] && r_r.page == 2'h0 && wb_dat_in[7:0] == PREFIX1) begin
            r_nxt.page = 2'h1; // RULE_20
          end else if (wb_sel_in[0] && r_r.page == 2'h0
                       && wb_dat_in[7:0] == PREFIX2) begin
            r_nxt.page = 2'h2; // RULE_20
          end else if (wb_sel_in[0] && r_r.page == 2'h0
                       && wb_dat_in[7:0] == PREFIX3) begin
            r_nxt.page = 2'h3; // RULE_20
          end else if (wb_sel_in[0]) begin
            // prefix + opcode + zero to three operands
            r_nxt.fopc = wb_dat_in[7:0];
            r_nxt.flen = {2'b00, r_r.page != 2'h0} + 3'h1
              + {1'b0, wb_dat_in[9:8]}; // RULE_21
            // pointer moves past the whole instruction
            r_nxt.ptr = r_r.ptr + {13'h0000, r_nxt.flen}; // RULE_01
            r_nxt.page = 2'h0;
          end
        end
        default: ;
      endcase
    end
    // operation dispatch
    if (wr_op) begin
      case (op_code)
        `CSFV_OP_ACCEPT, `CSFV_OP_XACCEPT: begin
          // stack context first, masks come later
          r_nxt.st = ST_PUSH;
          r_nxt.step = 2'h0;
          r_nxt.xacc = (op_code == `CSFV_OP_XACCEPT);
          r_nxt.vaddr = r_r.opw;
        end
        `CSFV_OP_RTI: begin
          r_nxt.st = ST_PULL; // RULE_22
          r_nxt.step = 2'h0;
        end
        `CSFV_OP_CLI: r_nxt.flags[`CSFV_FB_I] = 1'b0; // RULE_12
        `CSFV_OP_STOP: begin
          // stop disabled: plain no-op, flow continues
          if (!r_r.flags[`CSFV_FB_S]) r_nxt.stopped = 1'b1; // RULE_18
        end
        `CSFV_OP_CMP: r_nxt.flags = alu_flags; // RULE_08
        `CSFV_OP_LOAD, `CSFV_OP_STORE, `CSFV_OP_ADD, `CSFV_OP_ADC, `CSFV_OP_ABA,
        `CSFV_OP_SUB, `CSFV_OP_INC16, `CSFV_OP_DEC16, `CSFV_OP_ABX, `CSFV_OP_MOVE,
        `CSFV_OP_ROL, `CSFV_OP_MUL, `CSFV_OP_TAP: begin
          r_nxt.res = alu_res;
          r_nxt.flags = alu_flags; // RULE_05
        end
        default: ; // unknown codes do nothing
      endcase
    end
    // sequencer
    case (r_r.st)
      ST_CAPTURE: begin
        // straps sampled one edge after reset release
        r_nxt.mode = test_mode_in;
        r_nxt.cause = reset_cause_in;
        r_nxt.vaddr = vec_sel(test_mode_in, reset_cause_in); // RULE_02 RULE_03
        r_nxt.st = ST_VEC_HI;
      end
      ST_VEC_HI: begin
        // high address byte sits at vaddr, the lower of the two locations
        if (!r_r.mem_req) begin
          r_nxt.mem_req = 1'b1;
          r_nxt.mem_we = 1'b0;
          r_nxt.mem_addr = r_r.vaddr; // RULE_23
        end else if (mem_ack_in) begin
          r_nxt.mem_req = 1'b0;
          r_nxt.ptr[15:8] = mem_rdata_in; // RULE_19
          r_nxt.st = ST_VEC_LO;
        end
      end
      ST_VEC_LO: begin
        if (!r_r.mem_req) begin
          r_nxt.mem_req = 1'b1;
          r_nxt.mem_we = 1'b0;
          r_nxt.mem_addr = r_r.vaddr + 16'h0001; // RULE_23
        end else if (mem_ack_in) begin
          r_nxt.mem_req = 1'b0;
          r_nxt.ptr[7:0] = mem_rdata_in; // RULE_01
          r_nxt.st = ST_IDLE;
        end
      end
      ST_PUSH: begin
        // pointer low, pointer high, then flags
        if (!r_r.mem_req) begin
          r_nxt.mem_req = 1'b1;
          r_nxt.mem_we = 1'b1;
          r_nxt.mem_addr = r_r.sp;
          case (r_r.step)
            2'h0: r_nxt.mem_wdata = r_r.ptr[7:0];
            2'h1: r_nxt.mem_wdata = r_r.ptr[15:8];
            default: r_nxt.mem_wdata = r_r.flags;
          endcase
        end else if (mem_ack_in) begin
          r_nxt.mem_req = 1'b0;
          r_nxt.mem_we = 1'b0;
          r_nxt.sp = r_r.sp - 16'h0001;
          r_nxt.step = r_r.step + 2'h1;
          if (r_r.step == 2'h2) r_nxt.st = ST_MASK;
        end
      end
      ST_MASK: begin
        // masks set between stacking and vector fetch
        r_nxt.flags[`CSFV_FB_I] = 1'b1; // RULE_13
        if (r_r.xacc) r_nxt.flags[`CSFV_FB_X] = 1'b1; // RULE_16
        r_nxt.stopped = 1'b0;
        r_nxt.st = ST_VEC_HI;
      end
      ST_PULL: begin
        // reverse order: flags, pointer high, pointer low
        if (!r_r.mem_req) begin
          r_nxt.mem_req = 1'b1;
          r_nxt.mem_we = 1'b0;
          r_nxt.mem_addr = r_r.sp + 16'h0001;
        end else if (mem_ack_in) begin
          r_nxt.mem_req = 1'b0;
          r_nxt.sp = r_r.sp + 16'h0001;
          r_nxt.step = r_r.step + 2'h1;
          case (r_r.step)
            2'h0: r_nxt.flags = {mem_rdata_in[7],
              r_r.flags[`CSFV_FB_X] & mem_rdata_in[6], mem_rdata_in[5:0]}; // RULE_17
            2'h1: r_nxt.ptr[15:8] = mem_rdata_in;
            default: begin
              r_nxt.ptr[7:0] = mem_rdata_in; // RULE_22
              r_nxt.st = ST_IDLE;
            end
          endcase
        end
      end
      default: ; // idle: nothing running
    endcase
  end

  // ==========================================
  // state register, synchronous reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r_r <= RST_VAL; // RULE_12 RULE_15 RULE_18
    end else begin
      r_r <= r_nxt;
    end
  end

  // ==========================================
  // outputs
  assign wb_ack_out = r_r.wb_ack;
  assign wb_dat_out = r_r.wb_dat;
  assign mem_req_out = r_r.mem_req;
  assign mem_we_out = r_r.mem_we;
  assign mem_addr_out = r_r.mem_addr;
  assign mem_wdata_out = r_r.mem_wdata;
  assign next_instruction_pointer_out = r_r.ptr;
  assign flag_register_out = r_r.flags;
  assign stop_out = r_r.stopped;
  // requests stay pending outside; take only while unmasked
  assign irq_take_out = irq_in && !r_r.flags[`CSFV_FB_I]
    && (r_r.st == ST_IDLE); // RULE_11
  assign pin_take_out = dedicated_pin_interrupt_in && !r_r.flags[`CSFV_FB_X]
    && (r_r.st == ST_IDLE); // RULE_15

  // ==========================================
  // assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  property p_vec_normal;
    (r_r.st == ST_CAPTURE && !test_mode_in && reset_cause_in == `CSFV_CAUSE_WDG)
      |=> r_r.vaddr == 16'hFFFA ##1 r_r.mem_addr == 16'hFFFA;
  endproperty
  a_vec_normal: assert property (p_vec_normal) else $error("normal wdog vector"); // RULE_02

  property p_vec_test;
    (r_r.st == ST_CAPTURE && test_mode_in && reset_cause_in == `CSFV_CAUSE_POR)
      |=> r_r.vaddr == 16'hBFFE;
  endproperty
  a_vec_test: assert property (p_vec_test) else $error("test por vector"); // RULE_03

  property p_reset_masks;
    disable iff (1'b0) rst_in |=> (r_r.flags & 8'hD0) == 8'hD0;
  endproperty
  a_reset_masks: assert property (p_reset_masks) else $error("reset masks"); // RULE_12

  property p_x_sticky;
    (r_r.flags[`CSFV_FB_X] && !rst_in) |=> r_r.flags[`CSFV_FB_X]
      || $past(wr_op && op_code == `CSFV_OP_TAP) || $past(r_r.st == ST_PULL);
  endproperty
  a_x_sticky: assert property (p_x_sticky) else $error("pin mask cleared"); // RULE_17

  property p_mask_order;
    (r_r.st == ST_PUSH && r_r.step == 2'h2 && r_r.mem_req && mem_ack_in)
      |=> !r_r.mem_req ##1 (r_r.flags[`CSFV_FB_I] && r_r.st == ST_VEC_HI);
  endproperty
  a_mask_order: assert property (p_mask_order) else $error("mask order"); // RULE_13

  property p_irq_gate;
    r_r.flags[`CSFV_FB_I] |-> !irq_take_out;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("masked irq taken"); // RULE_11

  property p_stop_nop;
    (wr_op && op_code == `CSFV_OP_STOP && r_r.flags[`CSFV_FB_S] && !r_r.stopped)
      |=> !stop_out;
  endproperty
  a_stop_nop: assert property (p_stop_nop) else $error("stop not ignored"); // RULE_18

  property p_vec_pair;
    (r_r.st == ST_VEC_HI && r_r.mem_req && mem_ack_in)
      |=> ##[0:2] (r_r.mem_req && r_r.mem_addr == r_r.vaddr + 16'h0001);
  endproperty
  a_vec_pair: assert property (p_vec_pair) else $error("vector low byte"); // RULE_23

  property p_inc_z_only;
    (wr_op && op_code == `CSFV_OP_INC16)
      |=> (r_r.flags & 8'hFB) == ($past(r_r.flags) & 8'hFB);
  endproperty
  a_inc_z_only: assert property (p_inc_z_only) else $error("index op flags"); // RULE_09

  property p_move_none;
    (wr_op && (op_code == `CSFV_OP_MOVE || op_code == `CSFV_OP_ABX))
      |=> $stable(r_r.flags);
  endproperty
  a_move_none: assert property (p_move_none) else $error("move changed flags"); // RULE_05
endmodule

/* File: dv/csfv_mem_model.sv */
// byte-wide memory partner on the core's memory port
`timescale 1ns/1ps
module csfv_mem_model import csfv_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic slow_in,
  output logic [7:0] rdata_out,
  output logic ack_out
);
  // ==========================================
  // storage and answer timing
  logic [7:0] mem [0:65535]; // whole address space, bench presets it
  logic [1:0] wait_r; // stall count for slow answers
  // one ack per request; the data bus wanders between requests and holds during slow stalls,
  // so a core that samples off the ack edge never sees a stale byte
  always @(posedge clk_in) begin
    if (rst_in || ack_out || !req_in) begin
      ack_out <= 1'b0;
      wait_r <= 2'h0;
      rdata_out <= rst_in ? 8'hC3 : rdata_out + 8'h5B;
    end else if (slow_in && wait_r != 2'h3) begin
      wait_r <= wait_r + 2'h1; // slow answer: three idle cycles
    end else begin
      ack_out <= 1'b1;
      rdata_out <= mem[addr_in];
      if (we_in) mem[addr_in] <= wdata_in;
    end
  end
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the status flag and vector core
`timescale 1ns/1ps
`include "csfv_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD %0t got %h want %h", $time, (g), (e)); end end
module testbench import csfv_pkg::*;;
  // ==========================================
  // stimulus, wiring and the note queue
  logic clk_in = 1'b0;
  logic rst_r = 1'b1, cyc_r = 1'b0, we_r = 1'b0, tm_r = 1'b0;
  logic irq_r = 1'b0, pin_r = 1'b0, slow_r = 1'b0, quiet = 1'b0;
  logic [1:0] cause_r = 2'h0;
  logic [7:0] adr_r = 8'h00;
  logic [31:0] dat_r = 32'h0, rdat, wb_rd;
  logic wb_ack, mem_req, mem_we, mem_ack, stop, irq_take, pin_take;
  logic [15:0] mem_addr, nip, e, p;
  logic [7:0] mem_wd, mem_rd, flags;
  int failures = 0, n_checks = 0;
  typedef struct {logic [31:0] v; logic [31:0] m;} csfv_note_t;
  csfv_note_t q[$]; // expected read answers, oldest first
  logic [15:0] vt [6] = '{`CSFV_VEC_NRM_POR, `CSFV_VEC_NRM_CLK, `CSFV_VEC_NRM_WDG,
    `CSFV_VEC_TST_POR, `CSFV_VEC_TST_CLK, `CSFV_VEC_TST_WDG};
  logic [7:0] pf [4] = '{8'h00, 8'h18, 8'h1A, 8'hCD}; // no prefix, pages 1..3
  // op, a, b, flags, flag mask, result (FFFF: result not looked at)
  logic [55:0] rows [18] = '{
    56'h00_00_00_D4_FF_FFFF, 56'h00_80_00_D8_FF_FFFF, 56'h01_7F_00_D0_FF_FFFF,
    56'h02_0F_01_F0_FF_FFFF, 56'h02_7F_01_FA_FF_FFFF, 56'h02_FF_01_F5_FF_FFFF,
    56'h03_00_00_D0_FF_0001, 56'h04_08_08_F0_FF_0010, 56'h05_00_01_F9_FF_FFFF,
    56'h06_05_05_F4_FF_FFFF, 56'h08_00_02_F0_FF_0001, 56'h07_FF_FF_F4_FF_0000,
    56'h09_12_FF_F4_FF_13FE, 56'h0A_00_00_F4_FF_FFFF, 56'h0B_80_00_01_01_FFFF,
    56'h0B_00_00_00_01_0001, 56'h0C_10_08_01_01_0080, 56'h0C_10_04_00_01_0040};
  csfv_core u_csfv_core (.clk_in(clk_in), .rst_in(rst_r), .wb_cyc_in(cyc_r),
    .wb_stb_in(cyc_r), .wb_we_in(we_r), .wb_adr_in(adr_r), .wb_sel_in(4'hF),
    .wb_dat_in(dat_r), .wb_dat_out(wb_rd), .wb_ack_out(wb_ack), .test_mode_in(tm_r),
    .reset_cause_in(cause_r), .irq_in(irq_r), .dedicated_pin_interrupt_in(pin_r),
    .irq_take_out(irq_take), .pin_take_out(pin_take), .mem_req_out(mem_req),
    .mem_we_out(mem_we), .mem_addr_out(mem_addr), .mem_wdata_out(mem_wd),
    .mem_rdata_in(mem_rd), .mem_ack_in(mem_ack), .next_instruction_pointer_out(nip),
    .flag_register_out(flags), .stop_out(stop));
  csfv_mem_model u_mem (.clk_in(clk_in), .rst_in(rst_r), .req_in(mem_req),
    .we_in(mem_we), .addr_in(mem_addr), .wdata_in(mem_wd), .slow_in(slow_r),
    .rdata_out(mem_rd), .ack_out(mem_ack));
  initial forever #20 clk_in = ~clk_in; // 25 MHz
  // watcher: each read answer outside quiet polls is taken against the oldest note
  always @(posedge clk_in) begin
    if (wb_ack && !we_r) begin
      rdat = wb_rd;
      if (!quiet && q.size() != 0) begin
        `CHK(wb_rd & q[0].m, q[0].v)
        void'(q.pop_front());
      end
    end
  end
  // ==========================================
  // bus tasks; every wait is bounded
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_r <= 1'b1;
    we_r <= w;
    adr_r <= a;
    dat_r <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (!wb_ack && n < 50);
    cyc_r <= 1'b0;
    if (!wb_ack) begin failures++; print_verdict(); end
    @(posedge clk_in); // one idle cycle between requests
  endtask
  task automatic see(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    q.push_back('{v & m, m});
    wb(1'b0, a, 32'h0);
  endtask
  // poll busy quietly; ops and writes while busy would be dropped
  task automatic idle_wait;
    int n;
    n = 0;
    quiet = 1'b1;
    rdat = 32'h1;
    while (rdat[0] && n < 60) begin
      wb(1'b0, `CSFV_OFF_STAT, 32'h0);
      n++;
    end
    quiet = 1'b0;
    if (rdat[0]) begin failures++; print_verdict(); end
  endtask
  task automatic op(input logic [4:0] c, input logic [7:0] a, input logic [7:0] b);
    wb(1'b1, `CSFV_OFF_OPND, {a, b, b, a}); // w operand is {a, b}
    wb(1'b1, `CSFV_OFF_OP, {27'h0, c});
    idle_wait();
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_in);
    failures++;
    print_verdict();
  end
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(61602));
    for (int k = 0; k < 6; k++) begin
      e = 16'($urandom());
      u_mem.mem[vt[k]] = e[15:8];
      u_mem.mem[vt[k] + 16'h1] = e[7:0];
      rst_r <= 1'b1;
      tm_r <= (k > 2);
      cause_r <= 2'(k % 3);
      slow_r <= k[0]; // alternate prompt and slow memory
      repeat (12) @(posedge clk_in);
      rst_r <= 1'b0;
      @(posedge clk_in);
      idle_wait();
      see(`CSFV_OFF_PTR, {16'h0, e}, 32'hFFFF);
      `CHK(nip, e)
      see(`CSFV_OFF_FLAGS, 32'hD0, 32'hFF);
      see(`CSFV_OFF_STAT, {27'h0, 2'(k % 3), (k > 2), 2'h0}, 32'h1D);
    end
    see(8'hF0, 32'h0, 32'hFFFFFFFF); // unmapped place reads zero
    $display("test boot done");
    foreach (rows[i]) begin
      op(rows[i][52:48], rows[i][47:40], rows[i][39:32]);
      see(`CSFV_OFF_FLAGS, {24'h0, rows[i][31:24]}, {24'h0, rows[i][23:16]});
      if (rows[i][15:0] != 16'hFFFF) see(`CSFV_OFF_RES, {16'h0, rows[i][15:0]}, 32'hFFFF);
    end
    $display("test flags done");
    irq_r <= 1'b1;
    pin_r <= 1'b1;
    op(5'h0F, 8'h00, 8'h00); // stop while disabled
    see(`CSFV_OFF_STAT, 32'h0, 32'hE0);
    op(5'h0D, 8'h10, 8'h00);
    see(`CSFV_OFF_FLAGS, 32'h10, 32'hFF);
    see(`CSFV_OFF_STAT, 32'h80, 32'hC0);
    `CHK({pin_take, irq_take}, 2'b10)
    op(5'h0E, 8'h00, 8'h00);
    see(`CSFV_OFF_STAT, 32'hC0, 32'hC0);
    op(5'h0F, 8'h00, 8'h00);
    `CHK(stop, 1'b1)
    p = 16'($urandom());
    e = 16'($urandom());
    u_mem.mem[16'h2000] = e[15:8];
    u_mem.mem[16'h2001] = e[7:0];
    wb(1'b1, `CSFV_OFF_PTR, {16'h0, p});
    wb(1'b1, `CSFV_OFF_SP, 32'h0180);
    op(5'h10, 8'h20, 8'h00); // maskable accept, vector at 2000
    see(`CSFV_OFF_PTR, {16'h0, e}, 32'hFFFF);
    see(`CSFV_OFF_FLAGS, 32'h10, 32'hFF);
    see(`CSFV_OFF_SP, 32'h017D, 32'hFFFF);
    `CHK({u_mem.mem[16'h017E], u_mem.mem[16'h017F], u_mem.mem[16'h0180]}, {8'h00, p})
    `CHK(stop, 1'b0)
    op(5'h12, 8'h00, 8'h00);
    see(`CSFV_OFF_PTR, {16'h0, p}, 32'hFFFF);
    see(`CSFV_OFF_FLAGS, 32'h00, 32'hFF);
    op(5'h11, 8'h20, 8'h00); // pin accept
    see(`CSFV_OFF_FLAGS, 32'h50, 32'hFF);
    `CHK(flags, 8'h50)
    op(5'h12, 8'h00, 8'h00);
    see(`CSFV_OFF_FLAGS, 32'h00, 32'hFF);
    irq_r <= 1'b0;
    pin_r <= 1'b0;
    $display("test interrupts done");
    wb(1'b1, `CSFV_OFF_PTR, 32'h1000);
    e = 16'h1000;
    for (int i = 0; i < 4; i++) begin
      if (i > 0) wb(1'b1, `CSFV_OFF_FETCH, {24'h0, pf[i]});
      if (i > 0) see(`CSFV_OFF_STAT, 32'h2, 32'h2);
      wb(1'b1, `CSFV_OFF_FETCH, {22'h0, 2'(i), 8'h3A});
      e = e + 16'(i + (i > 0) + 1);
      // the page field clears once the opcode has been taken
      see(`CSFV_OFF_FETCH, {19'h0, 3'(i + (i > 0) + 1), 2'h0, 8'h3A}, 32'h1FFF);
      see(`CSFV_OFF_PTR, {16'h0, e}, 32'hFFFF);
    end
    $display("test fetch done");
    print_verdict();
  end
endmodule
